// *** hw/fol_params.svh ***
// Offset loader constants: widths, select codes, preset values and counts
`ifndef FOL_PARAMS_SVH
`define FOL_PARAMS_SVH

`define FOL_OFS_W       11
`define FOL_CHAIN_BITS  44
`define FOL_CNT_W       6
`define FOL_LAST_BIT    6'h2B
`define FOL_DATA_W      36
`define FOL_PAR_LAST    2'h3

`define FOL_SEL_P8      3'h0
`define FOL_SEL_P16     3'h1
`define FOL_SEL_P64     3'h2
`define FOL_SEL_P256    3'h3
`define FOL_SEL_P1024   3'h4
`define FOL_SEL_PAR     3'h5
`define FOL_SEL_SER     3'h6

`define FOL_PRESET_8    11'h008
`define FOL_PRESET_16   11'h010
`define FOL_PRESET_64   11'h040
`define FOL_PRESET_256  11'h100
`define FOL_PRESET_1024 11'h400

`endif

// *** hw/fol_pkg.sv ***
// Offset loader types
package fol_pkg;
	typedef enum logic [3:0] {
		fol_st_reset    = 4'h1,
		fol_st_serial   = 4'h2,
		fol_st_parallel = 4'h4,
		fol_st_done     = 4'h8
	} fol_state_type;
endpackage

// *** hw/fol_loader.sv ***
// Flag offset register loader: preset, parallel and serial programming
`include "fol_params.svh"

module fol_loader
	import fol_pkg::*;
(
	// Clock and master reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Offset select and serial pins
	input  wire logic                   offset_select0_serial_data,
	input  wire logic                   offset_select1_serial_enable,
	input  wire logic                   offset_select2,
	// Parallel load from wide port
	input  wire logic [`FOL_DATA_W-1:0] wide_port_data,
	input  wire logic                   parallel_write,
	// Loaded offsets
	output logic      [`FOL_OFS_W-1:0]  first_offset_fifo1,
	output logic      [`FOL_OFS_W-1:0]  second_offset_fifo1,
	output logic      [`FOL_OFS_W-1:0]  first_offset_fifo2,
	output logic      [`FOL_OFS_W-1:0]  second_offset_fifo2,
	// Loader status
	output logic                        serial_mode,
	output logic                        parallel_mode,
	output logic                        offsets_programmed
);

	fol_state_type                state;
	logic [2:0]                   sel_q;
	logic [2:0]                   sel_now;
	logic [`FOL_CHAIN_BITS-1:0]   chain;
	logic [`FOL_CNT_W-1:0]        bit_count;
	logic [1:0]                   par_count;
	logic                         shift_en;
	logic                         par_en;
	logic                         first_bit;

	// Preset decode
	function automatic logic [`FOL_OFS_W-1:0] preset_value(input logic [2:0] sel);
		logic [`FOL_OFS_W-1:0] v;
		v = `FOL_PRESET_8;
		case (sel)
			`FOL_SEL_P16:   v = `FOL_PRESET_16;
			`FOL_SEL_P64:   v = `FOL_PRESET_64;
			`FOL_SEL_P256:  v = `FOL_PRESET_256;
			`FOL_SEL_P1024: v = `FOL_PRESET_1024;
			default:        v = `FOL_PRESET_8;
		endcase
		return v;
	endfunction

	assign sel_now  = {offset_select2, offset_select1_serial_enable, offset_select0_serial_data};
	assign shift_en = (state == fol_st_serial) && !offset_select1_serial_enable;
	assign par_en   = (state == fol_st_parallel) && parallel_write;

	// Chain order: second fifo1, first fifo1, second fifo2, first fifo2
	assign second_offset_fifo1 = chain[3*`FOL_OFS_W +: `FOL_OFS_W];
	assign first_offset_fifo1  = chain[2*`FOL_OFS_W +: `FOL_OFS_W];
	assign second_offset_fifo2 = chain[1*`FOL_OFS_W +: `FOL_OFS_W];
	assign first_offset_fifo2  = chain[0 +: `FOL_OFS_W];

	assign serial_mode        = state[1];
	assign parallel_mode      = state[2];
	assign offsets_programmed = state[3];

	// Method select capture
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sel_q <= sel_now;
		end
	end

	// Loader state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= fol_st_reset;
		end else begin
			case (state)
				fol_st_reset: begin
					case (sel_q)
						`FOL_SEL_SER: state <= fol_st_serial;
						`FOL_SEL_PAR: state <= fol_st_parallel;
						default:      state <= fol_st_done;
					endcase
				end
				fol_st_serial: begin
					if (shift_en && bit_count == `FOL_LAST_BIT) begin
						state <= fol_st_done;
					end
				end
				fol_st_parallel: begin
					if (par_en && par_count == `FOL_PAR_LAST) begin
						state <= fol_st_done;
					end
				end
				fol_st_done: begin
					state <= fol_st_done;
				end
				default: begin
					state <= fol_st_reset;
				end
			endcase
		end
	end

	// Offset chain
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chain <= {4{preset_value(sel_now)}};
		end else if (shift_en) begin
			chain <= {chain[`FOL_CHAIN_BITS-2:0], offset_select0_serial_data};
		end else if (par_en) begin
			case (par_count)
				2'h0:    chain[2*`FOL_OFS_W +: `FOL_OFS_W] <= wide_port_data[`FOL_OFS_W-1:0];
				2'h1:    chain[3*`FOL_OFS_W +: `FOL_OFS_W] <= wide_port_data[`FOL_OFS_W-1:0];
				2'h2:    chain[0 +: `FOL_OFS_W] <= wide_port_data[`FOL_OFS_W-1:0];
				default: chain[1*`FOL_OFS_W +: `FOL_OFS_W] <= wide_port_data[`FOL_OFS_W-1:0];
			endcase
		end
	end

	// Serial bit counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bit_count <= '0;
		end else if (shift_en) begin
			bit_count <= bit_count + 1'b1;
		end
	end

	// Parallel word counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			par_count <= '0;
		end else if (par_en) begin
			par_count <= par_count + 1'b1;
		end
	end

	// First serial bit, kept for checking
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			first_bit <= 1'b0;
		end else if (shift_en && bit_count == '0) begin
			first_bit <= offset_select0_serial_data;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_sel_serial;
		$fell(sys_rst) && $past(sel_now) == `FOL_SEL_SER |=> state == fol_st_serial;
	endproperty
	a_sel_serial: assert property (p_sel_serial) else $error("serial method not entered");

	property p_preset;
		$fell(sys_rst) && $past(sel_now) == `FOL_SEL_P1024
			|-> first_offset_fifo1 == `FOL_PRESET_1024 && second_offset_fifo2 == `FOL_PRESET_1024 ##1 offsets_programmed;
	endproperty
	a_preset: assert property (p_preset) else $error("preset 1024 not loaded");

	property p_par_load;
		par_en && par_count == 2'h0 |=> first_offset_fifo1 == $past(wide_port_data[`FOL_OFS_W-1:0]);
	endproperty
	a_par_load: assert property (p_par_load) else $error("parallel word not loaded");

	property p_sel_parallel;
		$fell(sys_rst) && $past(sel_now) == `FOL_SEL_PAR |=> parallel_mode;
	endproperty
	a_sel_parallel: assert property (p_sel_parallel) else $error("parallel method not entered");

	property p_par_second;
		par_en && par_count == 2'h1 |=> second_offset_fifo1 == $past(wide_port_data[`FOL_OFS_W-1:0]);
	endproperty
	a_par_second: assert property (p_par_second) else $error("second parallel word not loaded");

	property p_par_done;
		par_en && par_count == `FOL_PAR_LAST |=> offsets_programmed
			&& second_offset_fifo2 == $past(wide_port_data[`FOL_OFS_W-1:0]);
	endproperty
	a_par_done: assert property (p_par_done) else $error("last parallel word not loaded");

	property p_sen_hold;
		state == fol_st_serial && offset_select1_serial_enable |=> $stable(chain) && $stable(bit_count);
	endproperty
	a_sen_hold: assert property (p_sen_hold) else $error("chain moved with enable high");

	property p_shift;
		shift_en |=> chain[0] == $past(offset_select0_serial_data)
			&& chain[`FOL_CHAIN_BITS-1:1] == $past(chain[`FOL_CHAIN_BITS-2:0]);
	endproperty
	a_shift: assert property (p_shift) else $error("serial shift wrong");

	property p_count;
		state == fol_st_serial |-> bit_count <= `FOL_LAST_BIT;
	endproperty
	a_count: assert property (p_count) else $error("too many serial bits");

	property p_last_done;
		shift_en && bit_count == `FOL_LAST_BIT |=> offsets_programmed && first_offset_fifo2[0] == $past(offset_select0_serial_data);
	endproperty
	a_last_done: assert property (p_last_done) else $error("sequence end wrong");

	property p_order;
		$rose(offsets_programmed) && $past(serial_mode) |-> second_offset_fifo1[`FOL_OFS_W-1] == first_bit;
	endproperty
	a_order: assert property (p_order) else $error("first bit not in msb");

	property p_hold;
		offsets_programmed |=> offsets_programmed && $stable(chain);
	endproperty
	a_hold: assert property (p_hold) else $error("offsets changed after load");

	c_serial_done: cover property (serial_mode ##1 offsets_programmed);
	c_par_done: cover property (parallel_mode ##1 offsets_programmed);
	c_preset: cover property ($fell(sys_rst) && $past(sel_now) == `FOL_SEL_P64);
	c_sen_pause: cover property (shift_en ##1 serial_mode && offset_select1_serial_enable ##1 shift_en);

endmodule

// *** sim/fol_host.sv ***
// Host controller model for the offset select and serial pins
`include "fol_params.svh"

module fol_host (
	// Clock and loader status
	input  wire logic clk,
	input  wire logic serial_mode,
	// Select and serial pins
	output logic      offset_select0_serial_data,
	output logic      offset_select1_serial_enable,
	output logic      offset_select2
);
	timeunit 1ns;
	timeprecision 100ps;
	integer seed = 32'hfd9b478a;
	initial {offset_select2, offset_select1_serial_enable, offset_select0_serial_data} = 3'h0;
	task automatic set_code(input logic [2:0] code);
		{offset_select2, offset_select1_serial_enable, offset_select0_serial_data} <= code;
	endtask
	// Bits go MSB first; idle cycles toggle data, extra writes follow the last bit
	task automatic shift_in(input logic [`FOL_CHAIN_BITS-1:0] v);
		int i;
		i = `FOL_CHAIN_BITS - 1;
		while (i >= -4) begin
			@(posedge clk);
			if (serial_mode !== 1'b1 && i == `FOL_CHAIN_BITS - 1)
				continue;
			if (($random(seed) & 3) == 0) begin
				offset_select1_serial_enable <= 1'b1;
				offset_select0_serial_data <= ~offset_select0_serial_data;
			end else begin
				offset_select1_serial_enable <= 1'b0;
				offset_select0_serial_data <= (i >= 0) ? v[i] : 1'($random(seed));
				i = i - 1;
			end
		end
		@(posedge clk);
		offset_select1_serial_enable <= 1'b1;
	endtask
endmodule

// *** sim/tb.sv ***
// Self-checking testbench for the flag offset loader
`include "fol_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, sys_rst, parallel_write, pin_sel0, pin_sel1, pin_sel2;
	logic serial_mode, parallel_mode, offsets_programmed;
	logic [35:0] wide_port_data, d;
	logic [10:0] ofs1a, ofs1b, ofs2a, ofs2b;
	logic [10:0] w [5];
	logic [43:0] v;
	integer seed, err_count = 0, tests_run = 0, cycles = 0;
	fol_loader DUT (.clk(clk), .sys_rst(sys_rst), .offset_select0_serial_data(pin_sel0),
		.offset_select1_serial_enable(pin_sel1), .offset_select2(pin_sel2), .wide_port_data(wide_port_data),
		.parallel_write(parallel_write), .first_offset_fifo1(ofs1a), .second_offset_fifo1(ofs1b),
		.first_offset_fifo2(ofs2a), .second_offset_fifo2(ofs2b), .serial_mode(serial_mode),
		.parallel_mode(parallel_mode), .offsets_programmed(offsets_programmed));
	fol_host host (.clk(clk), .serial_mode(serial_mode), .offset_select0_serial_data(pin_sel0),
		.offset_select1_serial_enable(pin_sel1), .offset_select2(pin_sel2));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [10:0] preset_of(input int c);
		case (c)
			1: return `FOL_PRESET_16;
			2: return `FOL_PRESET_64;
			3: return `FOL_PRESET_256;
			4: return `FOL_PRESET_1024;
			default: return `FOL_PRESET_8;
		endcase
	endfunction
	task automatic report_and_stop;
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Order: fifo1 second, fifo1 first, fifo2 second, fifo2 first
	task automatic chk_all(input logic [43:0] e);
		chk(ofs1b, e[43:33]);
		chk(ofs1a, e[32:22]);
		chk(ofs2b, e[21:11]);
		chk(ofs2a, e[10:0]);
		chk({10'h000, offsets_programmed}, 11'h001);
	endtask
	task automatic do_reset(input logic [2:0] code);
		@(posedge clk);
		sys_rst <= 1'b1;
		host.set_code(code);
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count = err_count + 1;
			report_and_stop;
		end
	end
	initial begin
		sys_rst = 1'b1;
		parallel_write = 1'b0;
		wide_port_data = 36'h0;
		seed = 32'hfd9b478a;
		for (int c = 0; c < 8; c++) begin
			if (c == 5 || c == 6)
				continue;
			do_reset(3'(c));
			repeat (3) @(posedge clk);
			#1;
			chk_all({4{preset_of(c)}});
		end
		do_reset(`FOL_SEL_PAR);
		@(posedge clk);
		#1;
		chk({10'h000, parallel_mode}, 11'h001);
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			d = 36'({$random(seed), $random(seed)});
			w[k] = d[10:0];
			parallel_write <= 1'b1;
			wide_port_data <= d;
		end
		@(posedge clk);
		parallel_write <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk_all({w[1], w[0], w[3], w[2]});
		chk({10'h000, parallel_mode}, 11'h000);
		for (int k = 0; k < 2; k++) begin
			v = k ? 44'h80000000001 : 44'({$random(seed), $random(seed)});
			do_reset(`FOL_SEL_SER);
			host.shift_in(v);
			repeat (2) @(posedge clk);
			#1;
			chk_all(v);
			chk({10'h000, serial_mode}, 11'h000);
		end
		report_and_stop;
	end
endmodule
